// ### inc/dmc_regs.vh
// Purpose: Constants for the DAC mode-control register bank
// Assumes: Included by rtl/dmc_mode_ctrl.v only
// Notes: Indices are register numbers; data fields are 8 bits wide
//
// What this block does
// - Bit 15 of a control word set means read, clear means write.
// - Registers 16-21 are read/write; 22 and 23 ignore writes.
// - Bits 14:8 carry the register index, bits 7:0 the data.
// - Left and right attenuation levels reset to all ones.
// - Attenuation is 0.5 dB times code minus 255.
// - Codes 0 to 14 fully mute the channel.
// - Each channel has its own independently programmed attenuator.
// - One load enable bit governs both attenuators.
// - Load enable low holds applied levels; high loads written levels; resets low.
// - Format select codes 000-101 as tabled, reset 101, 110/111 reserved.
// - In filter bypass mode the format field follows the external filter meaning.
// - De-emphasis rate 00 off, 01 48k, 10 44.1k, 11 32k; resets 00.
// - The de-emphasis rate applies only while de-emphasis is enabled.
// - De-emphasis enable resets off and acts on both channels.
// - In one-bit stream mode the rate field selects analog FIR performance.
// - Soft mute resets to 0 and acts on both channels together.
// - Soft mute ramps through a 256-step attenuator at the step rate.
// - Step rate codes 00-11 step once per 1, 2, 4, 8 frame clocks.
`ifndef DMC_REGS_VH
`define DMC_REGS_VH

// Control word layout
`define DMC_WORD_RW_BIT 15
`define DMC_WORD_IDX_MSB 14
`define DMC_WORD_IDX_LSB 8
`define DMC_WORD_DAT_MSB 7
`define DMC_WORD_DAT_LSB 0

// Register indices
`define DMC_IDX_LEFT 7'h10
`define DMC_IDX_RIGHT 7'h11
`define DMC_IDX_FMT 7'h12
`define DMC_IDX_FILT 7'h13
`define DMC_IDX_SYS 7'h14
`define DMC_IDX_ZERO 7'h15
`define DMC_IDX_ZFLAG 7'h16
`define DMC_IDX_ID 7'h17

// Writable and readable masks
`define DMC_MASK_FILT 8'hf7
`define DMC_MASK_SYS_WR 8'h7f
`define DMC_MASK_SYS_RD 8'h3f
`define DMC_MASK_ZERO 8'h07

// Reset values
`define DMC_RST_ATTEN 8'hff
`define DMC_RST_FMT 8'h50
`define DMC_RST_FILT 8'h00
`define DMC_RST_SYS 8'h00
`define DMC_RST_ZERO 8'h01
`define DMC_ID_DEFAULT 5'h00
`define DMC_RST_FMT_SEL 3'h5
`define DMC_RST_ZERO_OUT 3'h1

// Format/de-emphasis/mute register fields
`define DMC_FMT_LOAD 7
`define DMC_FMT_SEL_MSB 6
`define DMC_FMT_SEL_LSB 4
`define DMC_FMT_DMF_MSB 3
`define DMC_FMT_DMF_LSB 2
`define DMC_FMT_DME 1
`define DMC_FMT_MUTE 0
`define DMC_FMT_RESV_MIN 3'h6

// Output filter register fields
`define DMC_FILT_REV 7
`define DMC_FILT_ATS_MSB 6
`define DMC_FILT_ATS_LSB 5
`define DMC_FILT_OPE 4
`define DMC_FILT_DFMS 2
`define DMC_FILT_FLT 1
`define DMC_FILT_INZD 0

// System mode register fields
`define DMC_SYS_SRST 6
`define DMC_SYS_ONEBIT 5
`define DMC_SYS_BYPASS 4
`define DMC_SYS_MONO 3
`define DMC_SYS_CHSL 2
`define DMC_SYS_OS_MSB 1
`define DMC_SYS_OS_LSB 0

// Zero output register fields
`define DMC_ZERO_MSB 2
`define DMC_ZERO_LSB 0

// Attenuator, de-emphasis off and step codes
`define DMC_ATTEN_MUTE_MAX 8'h0e
`define DMC_ATTEN_FLOOR 8'h00
`define DMC_DMF_OFF 2'h0
`define DMC_STEP_ONE 3'h1

`endif

// ### rtl/dmc_mode_ctrl.v
// Purpose: Mode-control register bank and attenuator stepping of a stereo DAC
// Assumes: All inputs synchronous to sys_clk_i; frame clock far slower than sys_clk_i
// Notes: Registers reachable by plain strobe port or by 16-bit control words
//
// The strobed register port takes priority over control words in this implementation.
`timescale 1ns/1ps
`include "dmc_regs.vh"

module dmc_mode_ctrl #(
	parameter [4:0] DEVICE_ID = `DMC_ID_DEFAULT // Arbitrary neutral value
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [6:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	output reg reg_rvalid_o,
	input wire [15:0] ctl_word_i,
	input wire ctl_word_valid_i,
	input wire frame_rate_clock_i,
	input wire left_zero_flag_i,
	input wire right_zero_flag_i,
	output reg [7:0] left_gain_code_o,
	output reg [7:0] right_gain_code_o,
	output reg left_mute_o,
	output reg right_mute_o,
	output reg [2:0] audio_format_select_o,
	output reg format_ext_filter_o,
	output reg format_reserved_o,
	output reg [1:0] deemph_rate_o,
	output reg [1:0] fir_perf_select_o,
	output reg soft_mute_o,
	output reg output_invert_o,
	output reg dac_disable_o,
	output reg stereo_bypass_o,
	output reg slow_rolloff_o,
	output reg zero_mute_enable_o,
	output reg onebit_mode_o,
	output reg filter_bypass_mode_o,
	output reg mono_mode_o,
	output reg mono_right_o,
	output reg [1:0] os_rate_o,
	output reg [2:0] zero_out_ctrl_o,
	output reg sys_reset_pulse_o
);

////////////////////////////////////////////////////////////////////////////////

// Index compare, shared by write and read decode
function is_idx;
	input [6:0] idx;
	input [6:0] want;
	begin
		is_idx = (idx == want);
	end
endfunction

// One step toward the target code
function [7:0] step_toward;
	input [7:0] cur;
	input [7:0] tgt;
	begin
		if (cur < tgt) begin
			step_toward = cur + 8'h01;
		end else if (cur > tgt) begin
			step_toward = cur - 8'h01;
		end else begin
			step_toward = cur;
		end
	end
endfunction

// Code low enough to mean full mute
function is_mute;
	input [7:0] code;
	begin
		is_mute = (code <= `DMC_ATTEN_MUTE_MAX);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////

reg [7:0] left_atten_level_r;
reg [7:0] right_atten_level_r;
reg [7:0] fmt_ctrl_r;
reg [7:0] filt_ctrl_r;
reg [7:0] sys_ctrl_r;
reg [7:0] zero_ctrl_r;
reg [1:0] zero_flag_r;
reg srst_pend_r;
reg [7:0] applied_left_r;
reg [7:0] applied_right_r;
reg [7:0] cur_left_r;
reg [7:0] cur_right_r;
reg frame_prev_r;
reg [2:0] step_cnt_r;

// Merge strobe port and control word; strobe port has priority
wire bus_act = reg_wr_i | reg_rd_i;
wire word_rd = ctl_word_valid_i & ~bus_act & ctl_word_i[`DMC_WORD_RW_BIT];
wire word_wr = ctl_word_valid_i & ~bus_act & ~ctl_word_i[`DMC_WORD_RW_BIT];
wire acc_wr = reg_wr_i | word_wr;
wire acc_rd = reg_rd_i | word_rd;
wire [6:0] acc_idx = bus_act ? reg_addr_i :
	ctl_word_i[`DMC_WORD_IDX_MSB:`DMC_WORD_IDX_LSB];
wire [7:0] acc_dat = bus_act ? reg_wdata_i :
	ctl_word_i[`DMC_WORD_DAT_MSB:`DMC_WORD_DAT_LSB];

// Field views
wire load_en = fmt_ctrl_r[`DMC_FMT_LOAD];
wire soft_mute = fmt_ctrl_r[`DMC_FMT_MUTE];
wire deemph_enable = fmt_ctrl_r[`DMC_FMT_DME];
wire [1:0] deemph_rate_select = fmt_ctrl_r[`DMC_FMT_DMF_MSB:`DMC_FMT_DMF_LSB];
wire [2:0] fmt_sel = fmt_ctrl_r[`DMC_FMT_SEL_MSB:`DMC_FMT_SEL_LSB];

// Filter and system register fields
wire [1:0] atten_step_rate = filt_ctrl_r[`DMC_FILT_ATS_MSB:`DMC_FILT_ATS_LSB];
wire onebit = sys_ctrl_r[`DMC_SYS_ONEBIT];
wire bypass = sys_ctrl_r[`DMC_SYS_BYPASS];

////////////////////////////////////////////////////////////////////////////////

// Register writes; soft reset pulse restores the defaults of registers 16-21, not applied or ramp levels
always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		left_atten_level_r <= `DMC_RST_ATTEN;
		right_atten_level_r <= `DMC_RST_ATTEN;
		fmt_ctrl_r <= `DMC_RST_FMT;
		filt_ctrl_r <= `DMC_RST_FILT;
		sys_ctrl_r <= `DMC_RST_SYS;
		zero_ctrl_r <= `DMC_RST_ZERO;
		srst_pend_r <= 1'b0;
	end else if (srst_pend_r) begin
		// Soft reset: every writable register, 16-21, back to its default
		left_atten_level_r <= `DMC_RST_ATTEN;
		right_atten_level_r <= `DMC_RST_ATTEN;
		fmt_ctrl_r <= `DMC_RST_FMT;
		filt_ctrl_r <= `DMC_RST_FILT;
		sys_ctrl_r <= `DMC_RST_SYS;
		zero_ctrl_r <= `DMC_RST_ZERO;
		srst_pend_r <= 1'b0;
	end else begin
		// Normal access; a soft reset write arms the pulse
		srst_pend_r <= acc_wr & is_idx(acc_idx, `DMC_IDX_SYS) & acc_dat[`DMC_SYS_SRST];
		if (acc_wr) begin
			// Indices 22, 23 and unmapped fall to default: no change
			case (acc_idx)
				`DMC_IDX_LEFT: begin
					left_atten_level_r <= acc_dat;
				end
				`DMC_IDX_RIGHT: begin
					right_atten_level_r <= acc_dat;
				end
				`DMC_IDX_FMT: begin
					fmt_ctrl_r <= acc_dat;
				end
				`DMC_IDX_FILT: begin
					filt_ctrl_r <= acc_dat & `DMC_MASK_FILT;
				end
				`DMC_IDX_SYS: begin
					sys_ctrl_r <= acc_dat & `DMC_MASK_SYS_RD;
				end
				`DMC_IDX_ZERO: begin
					zero_ctrl_r <= acc_dat & `DMC_MASK_ZERO;
				end
				default: begin
					zero_ctrl_r <= zero_ctrl_r;
				end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////

// Read port: data only in the cycle after the strobe
always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		reg_rdata_o <= 8'h00;
		reg_rvalid_o <= 1'b0;
	end else begin
		reg_rvalid_o <= acc_rd;
		// Unmapped indices leave the data at zero
		reg_rdata_o <= 8'h00;
		if (acc_rd) begin
			if (is_idx(acc_idx, `DMC_IDX_LEFT)) begin
				reg_rdata_o <= left_atten_level_r;
			end else if (is_idx(acc_idx, `DMC_IDX_RIGHT)) begin
				reg_rdata_o <= right_atten_level_r;
			end else if (is_idx(acc_idx, `DMC_IDX_FMT)) begin
				reg_rdata_o <= fmt_ctrl_r;
			end else if (is_idx(acc_idx, `DMC_IDX_FILT)) begin
				reg_rdata_o <= filt_ctrl_r;
			end else if (is_idx(acc_idx, `DMC_IDX_SYS)) begin
				reg_rdata_o <= sys_ctrl_r & `DMC_MASK_SYS_RD;
			end else if (is_idx(acc_idx, `DMC_IDX_ZERO)) begin
				reg_rdata_o <= zero_ctrl_r;
			end else if (is_idx(acc_idx, `DMC_IDX_ZFLAG)) begin
				reg_rdata_o <= {6'h00, zero_flag_r};
			end else if (is_idx(acc_idx, `DMC_IDX_ID)) begin
				reg_rdata_o <= {3'h0, DEVICE_ID};
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////

// Zero flags captured every cycle for the flag register
always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		zero_flag_r <= 2'h0;
	end else begin
		zero_flag_r <= {right_zero_flag_i, left_zero_flag_i};
	end
end

// Step tick: every 1, 2, 4 or 8 frame clock rising edges
wire frame_edge = frame_rate_clock_i & ~frame_prev_r;
wire [2:0] step_last = (`DMC_STEP_ONE << atten_step_rate) - `DMC_STEP_ONE;
wire step_tick = frame_edge & (step_cnt_r >= step_last);

always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		frame_prev_r <= 1'b0;
		step_cnt_r <= 3'h0;
	end else begin
		frame_prev_r <= frame_rate_clock_i;
		// Counter restarts at each tick
		if (step_tick) begin
			step_cnt_r <= 3'h0;
		end else if (frame_edge) begin
			step_cnt_r <= step_cnt_r + 3'h1;
		end
	end
end

// Applied levels follow stored ones only while loading is enabled
always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		applied_left_r <= `DMC_RST_ATTEN;
		applied_right_r <= `DMC_RST_ATTEN;
	end else if (load_en) begin
		applied_left_r <= left_atten_level_r;
		applied_right_r <= right_atten_level_r;
	end
end

// Current codes ramp one step per tick toward level or mute floor
wire [7:0] tgt_left = soft_mute ? `DMC_ATTEN_FLOOR : applied_left_r;
wire [7:0] tgt_right = soft_mute ? `DMC_ATTEN_FLOOR : applied_right_r;

always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		cur_left_r <= `DMC_RST_ATTEN;
		cur_right_r <= `DMC_RST_ATTEN;
	end else if (step_tick) begin
		cur_left_r <= step_toward(cur_left_r, tgt_left);
		cur_right_r <= step_toward(cur_right_r, tgt_right);
	end
end

////////////////////////////////////////////////////////////////////////////////

// Attenuator outputs, one cycle behind the ramp
always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		left_gain_code_o <= `DMC_RST_ATTEN;
		right_gain_code_o <= `DMC_RST_ATTEN;
		left_mute_o <= 1'b0;
		right_mute_o <= 1'b0;
	end else begin
		// Gain code c means 0.5 dB x (c - 255)
		left_gain_code_o <= cur_left_r;
		right_gain_code_o <= cur_right_r;
		left_mute_o <= is_mute(cur_left_r);
		right_mute_o <= is_mute(cur_right_r);
	end
end

// Format, de-emphasis and soft mute outputs
always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		audio_format_select_o <= `DMC_RST_FMT_SEL;
		format_ext_filter_o <= 1'b0;
		format_reserved_o <= 1'b0;
		deemph_rate_o <= `DMC_DMF_OFF;
		fir_perf_select_o <= `DMC_DMF_OFF;
		soft_mute_o <= 1'b0;
	end else begin
		// Reserved codes flagged only outside bypass
		audio_format_select_o <= fmt_sel;
		format_ext_filter_o <= bypass;
		format_reserved_o <= ~bypass & (fmt_sel >= `DMC_FMT_RESV_MIN);
		deemph_rate_o <= (deemph_enable & ~onebit) ? deemph_rate_select :
			`DMC_DMF_OFF;
		fir_perf_select_o <= onebit ? deemph_rate_select : `DMC_DMF_OFF;
		soft_mute_o <= soft_mute;
	end
end

// Output filter control outputs
always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		output_invert_o <= 1'b0;
		dac_disable_o <= 1'b0;
		stereo_bypass_o <= 1'b0;
		slow_rolloff_o <= 1'b0;
		zero_mute_enable_o <= 1'b0;
	end else begin
		output_invert_o <= filt_ctrl_r[`DMC_FILT_REV];
		dac_disable_o <= filt_ctrl_r[`DMC_FILT_OPE];
		stereo_bypass_o <= filt_ctrl_r[`DMC_FILT_DFMS];
		slow_rolloff_o <= filt_ctrl_r[`DMC_FILT_FLT];
		zero_mute_enable_o <= filt_ctrl_r[`DMC_FILT_INZD] & ~onebit;
	end
end

// System mode outputs
always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		onebit_mode_o <= 1'b0;
		filter_bypass_mode_o <= 1'b0;
		mono_mode_o <= 1'b0;
		mono_right_o <= 1'b0;
		os_rate_o <= 2'h0;
	end else begin
		// Right channel choice only matters in mono
		onebit_mode_o <= onebit;
		filter_bypass_mode_o <= bypass;
		mono_mode_o <= sys_ctrl_r[`DMC_SYS_MONO];
		mono_right_o <= sys_ctrl_r[`DMC_SYS_MONO] & sys_ctrl_r[`DMC_SYS_CHSL];
		os_rate_o <= sys_ctrl_r[`DMC_SYS_OS_MSB:`DMC_SYS_OS_LSB];
	end
end

// Zero output control and soft reset pulse
always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		zero_out_ctrl_o <= `DMC_RST_ZERO_OUT;
		sys_reset_pulse_o <= 1'b0;
	end else begin
		zero_out_ctrl_o <= zero_ctrl_r[`DMC_ZERO_MSB:`DMC_ZERO_LSB];
		sys_reset_pulse_o <= srst_pend_r;
	end
end

endmodule

// ### test/dmc_chk.sv
// Purpose: Port-level checks of the mode-control bank
// Assumes: One clock, async active-low reset
// Notes: Bound into every instance of the bank
`timescale 1ns/1ps
module dmc_chk #(
	parameter [4:0] DEVICE_ID = 5'h00
) (
	input logic sys_clk_i,
	input logic rst_n_i,
	input logic [6:0] reg_addr_i,
	input logic [7:0] reg_wdata_i,
	input logic reg_wr_i,
	input logic reg_rd_i,
	input logic [7:0] reg_rdata_o,
	input logic reg_rvalid_o,
	input logic [15:0] ctl_word_i,
	input logic ctl_word_valid_i,
	input logic [7:0] left_gain_code_o,
	input logic left_mute_o,
	input logic [2:0] audio_format_select_o,
	input logic format_ext_filter_o,
	input logic format_reserved_o,
	input logic [1:0] deemph_rate_o,
	input logic [1:0] fir_perf_select_o,
	input logic onebit_mode_o,
	input logic sys_reset_pulse_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic rd_req;
	////////////////////////////////////////////////////////////////
	// Any read request, strobe or control word
	assign rd_req = reg_rd_i | (ctl_word_valid_i & ctl_word_i[15] & ~reg_wr_i);
	sequence sreset_wr;
		reg_wr_i && reg_addr_i == 7'h14 && reg_wdata_i[6];
	endsequence
	sequence pulse_once;
		sys_reset_pulse_o ##1 !sys_reset_pulse_o;
	endsequence
	////////////////////////////////////////////////////////////////
	chk_read_answer: assert property (reg_rvalid_o == $past(rd_req))
		else $error("read answer timing");
	chk_rdata_idle: assert property (!reg_rvalid_o |-> reg_rdata_o == 8'h00)
		else $error("read data not cleared");
	chk_id_read: assert property (reg_rd_i && reg_addr_i == 7'h17 |=>
		reg_rdata_o == {3'h0, DEVICE_ID}) else $error("identifier read");
	chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i[6:3] != 4'h2 |=>
		reg_rdata_o == 8'h00) else $error("unmapped read");
	chk_mute_code: assert property (left_mute_o == (left_gain_code_o <= 8'h0e))
		else $error("mute flag");
	chk_gain_step: assert property ($changed(left_gain_code_o) |->
		left_gain_code_o - $past(left_gain_code_o) == 8'h01 ||
		$past(left_gain_code_o) - left_gain_code_o == 8'h01) else $error("gain jump");
	chk_fmt_reserved: assert property (format_reserved_o ==
		(!format_ext_filter_o && audio_format_select_o[2:1] == 2'h3)) else $error("reserved flag");
	chk_deemph_gate: assert property (deemph_rate_o != 2'h0 |-> !onebit_mode_o)
		else $error("de-emphasis gate");
	chk_fir_gate: assert property (fir_perf_select_o != 2'h0 |-> onebit_mode_o)
		else $error("fir select gate");
	chk_soft_pulse: assert property (sreset_wr |-> ##1 !sys_reset_pulse_o ##1 pulse_once)
		else $error("soft reset pulse");
endmodule
bind dmc_mode_ctrl dmc_chk #(.DEVICE_ID(DEVICE_ID)) u_chk (.sys_clk_i, .rst_n_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .ctl_word_i,
	.ctl_word_valid_i, .left_gain_code_o, .left_mute_o, .audio_format_select_o,
	.format_ext_filter_o, .format_reserved_o, .deemph_rate_o, .fir_perf_select_o,
	.onebit_mode_o, .sys_reset_pulse_o);

// ### test/dmc_far_model.sv
// Purpose: Frame clock and zero flag source
// Assumes: Frame clock runs free, synchronous to sys_clk_i
// Notes: Zero flags follow the bench one cycle later
`timescale 1ns/1ps
module dmc_far_model #(
	parameter int HALF = 4
) (
	input logic sys_clk_i,
	input logic rst_n_i,
	input logic zero_l_i,
	input logic zero_r_i,
	output logic frame_o,
	output logic zero_l_o,
	output logic zero_r_o
);
	int cnt_r;
	// Frame clock divider and flag registers
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= 0;
			frame_o <= 1'b0;
		end else if (cnt_r == HALF - 1) begin
			cnt_r <= 0;
			frame_o <= ~frame_o;
		end else begin
			cnt_r <= cnt_r + 1;
		end
		zero_l_o <= zero_l_i;
		zero_r_o <= zero_r_i;
	end
endmodule

// ### test/tb.sv
// Purpose: Self-checking bench of the mode-control bank
// Assumes: Frame period of 8 clocks
// Notes: Reads are noted in a queue and matched by a monitor
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module tb;
	logic sys_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, ctl_word_valid_i = 0;
	logic [6:0] reg_addr_i = 0;
	logic [7:0] reg_wdata_i = 0, e, d, m;
	logic [15:0] ctl_word_i = 0, seed = 16'd16750;
	logic zl = 1, zr = 0;
	wire [7:0] reg_rdata_o, left_gain_code_o, right_gain_code_o;
	wire [2:0] audio_format_select_o, zero_out_ctrl_o;
	wire [1:0] deemph_rate_o, fir_perf_select_o, os_rate_o;
	wire reg_rvalid_o, frame_rate_clock_i, left_zero_flag_i, right_zero_flag_i, left_mute_o;
	wire right_mute_o, format_ext_filter_o, format_reserved_o, soft_mute_o, output_invert_o;
	wire dac_disable_o, stereo_bypass_o, slow_rolloff_o, zero_mute_enable_o, onebit_mode_o;
	wire filter_bypass_mode_o, mono_mode_o, mono_right_o, sys_reset_pulse_o;
	int err_count = 0, check_count = 0;
	logic [7:0] exp_q[$];
	localparam [4:0] ID = 5'h0b; // Arbitrary identifier value
	localparam logic [63:0] MASK = 64'h0000073ff7ffffff; // Byte i: writable bits of index 16+i
	dmc_mode_ctrl #(.DEVICE_ID(ID)) DUT (.*);
	dmc_far_model far (.sys_clk_i, .rst_n_i, .zero_l_i(zl), .zero_r_i(zr),
		.frame_o(frame_rate_clock_i), .zero_l_o(left_zero_flag_i), .zero_r_o(right_zero_flag_i));
	initial begin
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 7);
		seed = seed ^ (seed >> 9);
		seed = seed ^ (seed << 8);
		return seed[7:0];
	endfunction
	task automatic bus(input logic w, input logic r, input logic [6:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		reg_wr_i <= w;
		reg_rd_i <= r;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		ctl_word_valid_i <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		bus(0, 1, a, 0);
	endtask
	task automatic word(input logic [15:0] w, input logic [7:0] x);
		if (w[15]) exp_q.push_back(x);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		ctl_word_valid_i <= 1'b1;
		ctl_word_i <= w;
	endtask
	task automatic idle(input int n);
		bus(0, 0, 0, 0);
		repeat (n) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Read monitor matches answers against notes
	always @(posedge sys_clk_i) begin
		if (reg_rvalid_o === 1'b1) begin
			m = exp_q.size() ? exp_q.pop_front() : 8'hxx;
			`CHK(reg_rdata_o, m)
		end
	end
	// Watchdog
	initial begin
		#2000000;
		err_count++;
		complete_run();
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd(7'h10, 8'hff);
		rd(7'h11, 8'hff);
		rd(7'h12, 8'h50);
		rd(7'h05, 8'h00);
		bus(1, 0, 7'h10, 8'h40);
		bus(1, 0, 7'h11, 8'h80);
		idle(200);
		`CHK(left_gain_code_o, 8'hff)
		$display("test reset and load hold done");
		bus(1, 0, 7'h12, 8'hd0);
		idle(1700);
		`CHK(left_gain_code_o, 8'h40)
		`CHK(right_gain_code_o, 8'h80)
		bus(1, 0, 7'h10, 8'h05);
		idle(600);
		`CHK(left_mute_o, 1'b1)
		`CHK(right_mute_o, 1'b0)
		bus(1, 0, 7'h13, 8'h20);
		bus(1, 0, 7'h12, 8'hd1);
		idle(1000);
		`CHK(right_gain_code_o > 8'h20, 1'b1)
		idle(1300);
		`CHK(right_gain_code_o, 8'h00)
		`CHK(soft_mute_o, 1'b1)
		$display("test attenuator done");
		for (int f = 0; f < 8; f++) begin
			bus(1, 0, 7'h12, {1'b0, f[2:0], f[1:0], f[2], 1'b0});
			idle(2);
			`CHK(audio_format_select_o, f[2:0])
			`CHK(format_reserved_o, f > 5)
			`CHK(deemph_rate_o, f[2] ? f[1:0] : 2'h0)
		end
		bus(1, 0, 7'h14, 8'h20);
		bus(1, 0, 7'h12, 8'h1e);
		idle(2);
		`CHK(deemph_rate_o, 2'h0)
		`CHK(fir_perf_select_o, 2'h3)
		bus(1, 0, 7'h14, 8'h10);
		bus(1, 0, 7'h12, 8'h60);
		idle(2);
		`CHK(format_reserved_o, 1'b0)
		bus(1, 0, 7'h13, 8'h97);
		bus(1, 0, 7'h14, 8'h0f);
		bus(1, 0, 7'h15, 8'h06);
		idle(2);
		`CHK({output_invert_o, dac_disable_o, stereo_bypass_o, slow_rolloff_o}, 4'hf)
		`CHK({zero_mute_enable_o, onebit_mode_o, filter_bypass_mode_o}, 3'h4)
		`CHK({mono_mode_o, mono_right_o, os_rate_o}, 4'hf)
		`CHK(zero_out_ctrl_o, 3'h6)
		$display("test mode fields done");
		word({1'b0, 7'h11, 8'h3c}, 0);
		word({1'b1, 7'h11, 8'h00}, 8'h3c);
		{zr, zl} <= 2'h2;
		for (int i = 0; i < 8; i++) begin
			d = rnd() & (i == 4 ? 8'hbf : 8'hff);
			e = (d & MASK[8 * i +: 8]) | (i == 6 ? {6'h0, zr, zl} : i == 7 ? {3'h0, ID} : 8'h00);
			bus(1, 0, 7'h10 + i, d);
			rd(7'h10 + i, e);
		end
		bus(1, 0, 7'h14, 8'h40);
		idle(1);
		`CHK(sys_reset_pulse_o, 1'b1)
		idle(1);
		`CHK(sys_reset_pulse_o, 1'b0)
		`CHK(zero_out_ctrl_o, 3'h1)
		rd(7'h12, 8'h50);
		rd(7'h15, 8'h01);
		idle(3);
		$display("test access kinds done");
		`CHK(exp_q.size(), 0)
		complete_run();
	end
endmodule
